// File: hdl/gpio_params.svh
// Purpose: offsets, reset values and field layouts of the four-port parallel I/O block
// Assumes: byte registers, each on one 32-bit Avalon word
// Notes:   definitions only
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
`define OFS_PORT_A_LATCH     8'h00
`define OFS_PORT_B_LATCH     8'h01
`define OFS_PORT_C_LATCH     8'h02
`define OFS_PORT_D_LATCH     8'h03
`define OFS_PORT_A_DIR       8'h04
`define OFS_PORT_B_DIR       8'h05
`define OFS_PORT_C_DIR       8'h06
`define OFS_PORT_D_DIR       8'h07
`define OFS_LED_ENABLE       8'h0c
`define DIR_RESET            8'h00
`define LED_RESET            8'h00
`define LED_MASK             8'h3f
`define ADC_SEL_W            5
`define ADC_CH_A_FIRST       5'h00
`define ADC_CH_B_FIRST       5'h04
`define ADC_CH_COUNT         5'h06
`endif

// File: hdl/gpio_pkg.sv
// Purpose: types for the four-port parallel I/O block
// Assumes: gpio_params.svh holds the numbers
// Notes:   state is one packed struct
package gpio_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;
   typedef struct packed {
      logic [3:0] fe_q;
      logic [3:0] ar_q;
      byte_t      rdata_q;
   } unused_t;
   typedef struct packed {
      byte_t [3:0] latch_q;
      byte_t [3:0] dir_q;
      byte_t       led_q;
      byte_t [3:0] sync1_q;
      byte_t [3:0] sync2_q;
      byte_t [3:0] sync3_q;
      byte_t [3:0] pin_q;
      bus_state_t  bus_q;
      logic [31:0] rdata_q;
   } state_t;
endpackage : gpio_pkg

// File: hdl/parallel_io_ports.sv
// Purpose: four 8-bit bidirectional ports with latches, direction and LED enable registers
// Assumes: Avalon-MM slave with waitrequest, word addresses, one clock MCLK, sync RESET
// Notes:   latches are not reset; pins are split into in/out/oe, no tristate here
//
// What this block does
// R1: each port has an 8-bit read/write latch that no reset touches.
// R2: latches at 0x00-0x03, directions at 0x04-0x07, LED enables at 0x0c.
// R3: direction one enables a pin driver, zero leaves the pin input.
// R4: reset clears all direction bits so every pin starts as input.
// R5: each pin uses the same-index bit of its port's direction register.
// R6: keypad channel enables take port A bits 0-3 and port D bits 4-7.
// R7: analog channel select hands port A bits 4-7 or B bits 6-7 to ADC.
// R8: serial, timer, frontplane and SPI enables take their pins over from port logic.
// R9: software should load the latch before turning a driver on.
// R10: reading data gives latch for outputs and synchronised pin level for inputs.
// R11: data writes with byte enable bit 0 set update the latch whatever the direction.
// R12: six LED enables act on port B pins 0-5 only while output.
// R13: access completes in one cycle; unimplemented bits read zero, writes ignored.
`timescale 1ns/1ps
`include "gpio_params.svh"

module parallel_io_ports
   import gpio_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RESET,
   input  wire logic        CLK_EN,
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic [31:0] PIN_IN,
   output logic      [31:0] PIN_OUT,
   output logic      [31:0] PIN_OE,
   output logic      [31:0] PIN_PERIPH,
   output logic      [5:0]  LED_SINK,
   input  wire logic [7:0]  KEYPAD_CHANNEL_ENABLE,
   input  wire logic [4:0]  ANALOG_CHANNEL_SELECT,
   input  wire logic        SERIAL_INTERFACE_ENABLE,
   input  wire logic [3:0]  TIMER_EDGE_LEVEL_SELECT,
   input  wire logic        FRONTPLANE_LOW_HALF_ENABLE,
   input  wire logic        FRONTPLANE_HIGH_HALF_ENABLE,
   input  wire logic        SPI_UNIT_ENABLE
);

   state_t     s_q;
   state_t     s_d;
   logic [31:0] periph;
   logic [31:0] latch_flat;
   logic [31:0] dir_flat;
   logic [7:0]  analog_a;
   logic [7:0]  analog_b;
   logic        access;
   logic        wr_hit;
   logic [7:0]  wbyte;

   // analog select: channels 0-3 on port A bits 4-7, channels 4-5 on port B bits 6-7
   always_comb begin
      analog_a = 8'h00;
      analog_b = 8'h00;
      if (ANALOG_CHANNEL_SELECT < `ADC_CH_B_FIRST) begin
         analog_a[4 + ANALOG_CHANNEL_SELECT[1:0]] = 1'b1; // [R7]
      end else if (ANALOG_CHANNEL_SELECT < `ADC_CH_COUNT) begin
         analog_b[6 + {1'b0, ANALOG_CHANNEL_SELECT[0]}] = 1'b1; // [R7]
      end
   end

   // ownership by sharing peripherals; an owned pin loses PIN_OE and PIN_OUT, but read-back and LED_SINK still use it
   always_comb begin
      periph        = 32'h0000_0000;
      periph[3:0]   = KEYPAD_CHANNEL_ENABLE[3:0];                   // [R6]
      periph[31:28] = KEYPAD_CHANNEL_ENABLE[7:4];                   // [R6]
      periph[7:4]   = analog_a[7:4];                                // [R7]
      periph[15:14] = analog_b[7:6];                                // [R7]
      periph[9:8]   = {2{SERIAL_INTERFACE_ENABLE}};                 // [R8]
      periph[13:10] = TIMER_EDGE_LEVEL_SELECT;                      // [R8]
      periph[19:16] = {4{FRONTPLANE_LOW_HALF_ENABLE}};              // [R8]
      periph[23:20] = {4{FRONTPLANE_HIGH_HALF_ENABLE}};             // [R8]
      periph[27:24] = {4{SPI_UNIT_ENABLE}};                         // [R8]
   end

   assign latch_flat = s_q.latch_q;
   assign dir_flat   = s_q.dir_q;
   assign access     = (AVS_READ | AVS_WRITE) & (s_q.bus_q == BUS_IDLE);
   assign wr_hit     = AVS_WRITE & (s_q.bus_q == BUS_IDLE) & AVS_BYTEENABLE[0];
   assign wbyte      = AVS_WRITEDATA[7:0];

   always_comb begin
      s_d = s_q;
      // three-stage pin sampler; stage 1 feeds stage 2 only
      s_d.sync1_q = PIN_IN;
      s_d.sync2_q = s_q.sync1_q;
      s_d.sync3_q = s_q.sync2_q;
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (s_q.sync2_q[p][b] == s_q.sync3_q[p][b]) begin
               s_d.pin_q[p][b] = s_q.sync3_q[p][b];
            end
         end
      end
      case (s_q.bus_q)
         BUS_IDLE: begin
            if (access) begin
               s_d.bus_q = BUS_ACK;
            end
         end
         BUS_ACK:  s_d.bus_q = BUS_IDLE;
         default:  s_d.bus_q = BUS_IDLE;
      endcase
      if (wr_hit) begin
         case ({4'h0, AVS_ADDRESS})
            `OFS_PORT_A_LATCH: s_d.latch_q[0] = wbyte; // [R11] [R2]
            `OFS_PORT_B_LATCH: s_d.latch_q[1] = wbyte; // [R11]
            `OFS_PORT_C_LATCH: s_d.latch_q[2] = wbyte; // [R11]
            `OFS_PORT_D_LATCH: s_d.latch_q[3] = wbyte; // [R11]
            `OFS_PORT_A_DIR:   s_d.dir_q[0]   = wbyte; // [R2]
            `OFS_PORT_B_DIR:   s_d.dir_q[1]   = wbyte;
            `OFS_PORT_C_DIR:   s_d.dir_q[2]   = wbyte;
            `OFS_PORT_D_DIR:   s_d.dir_q[3]   = wbyte;
            `OFS_LED_ENABLE:   s_d.led_q      = wbyte & `LED_MASK; // [R13]
            default: ;
         endcase
      end
      if (AVS_READ && s_q.bus_q == BUS_IDLE) begin
         s_d.rdata_q = 32'h0000_0000; // [R13]
         case ({4'h0, AVS_ADDRESS})
            `OFS_PORT_A_LATCH, `OFS_PORT_B_LATCH, `OFS_PORT_C_LATCH, `OFS_PORT_D_LATCH: begin
               // outputs read back the latch, inputs the sampled pin
               s_d.rdata_q[7:0] = (s_q.latch_q[AVS_ADDRESS[1:0]] & s_q.dir_q[AVS_ADDRESS[1:0]])
                  | (s_q.pin_q[AVS_ADDRESS[1:0]] & ~s_q.dir_q[AVS_ADDRESS[1:0]]); // [R10]
            end
            `OFS_PORT_A_DIR, `OFS_PORT_B_DIR, `OFS_PORT_C_DIR, `OFS_PORT_D_DIR: begin
               s_d.rdata_q[7:0] = s_q.dir_q[AVS_ADDRESS[1:0]];
            end
            `OFS_LED_ENABLE: s_d.rdata_q[7:0] = s_q.led_q;
            default: s_d.rdata_q = 32'h0000_0000; // [R13]
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         // latches keep their contents through reset [R1]
         s_q.dir_q   <= {4{`DIR_RESET}}; // [R4]
         s_q.led_q   <= `LED_RESET;
         s_q.bus_q   <= BUS_IDLE;
         s_q.rdata_q <= 32'h0000_0000;
         s_q.sync1_q <= {4{8'h00}};
         s_q.sync2_q <= {4{8'h00}};
         s_q.sync3_q <= {4{8'h00}};
         s_q.pin_q   <= {4{8'h00}};
      end else if (CLK_EN) begin
         s_q <= s_d; // [R1]
      end
   end

   // pins owned by a peripheral are released here; the peripheral drives them
   assign PIN_OE          = dir_flat & ~periph;    // [R3] [R5] [R6] [R7] [R8]
   assign PIN_OUT         = latch_flat & PIN_OE;   // [R3]
   assign PIN_PERIPH      = periph;
   assign LED_SINK        = s_q.led_q[5:0] & s_q.dir_q[1][5:0]; // [R12]
   assign AVS_READDATA    = s_q.rdata_q;
   // wait one cycle, answer on the next: one-cycle access
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (s_q.bus_q == BUS_IDLE); // [R13]

   property p_dir_reset;
      @(posedge MCLK) RESET |=> (PIN_OE == 32'h0000_0000);
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("outputs enabled after reset"); // [R4]

   sequence s_latch_write;
      AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 && CLK_EN;
   endsequence
   property p_latch_write;
      @(posedge MCLK) disable iff (RESET)
      (AVS_WRITE && AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 && AVS_BYTEENABLE[0] && CLK_EN)
      |=> (s_q.latch_q[0] == $past(AVS_WRITEDATA[7:0]));
   endproperty
   a_latch_write: assert property (p_latch_write) else $error("latch not written"); // [R11]

   property p_one_cycle;
      @(posedge MCLK) disable iff (RESET)
      (AVS_READ && AVS_WAITREQUEST && CLK_EN) |=> !AVS_WAITREQUEST;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("access not one cycle"); // [R13]

   property p_oe_dir;
      @(posedge MCLK) disable iff (RESET)
      (PIN_OE & ~dir_flat) == 32'h0000_0000;
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("driver enable mismatch"); // [R3]

   property p_keypad;
      @(posedge MCLK) disable iff (RESET)
      KEYPAD_CHANNEL_ENABLE[0] |-> !PIN_OE[0] && PIN_PERIPH[0];
   endproperty
   a_keypad: assert property (p_keypad) else $error("keypad pin still driven"); // [R6]

   property p_analog;
      @(posedge MCLK) disable iff (RESET)
      (ANALOG_CHANNEL_SELECT == 5'h05) |-> PIN_PERIPH[15] && !PIN_PERIPH[14];
   endproperty
   a_analog: assert property (p_analog) else $error("analog pin not handed over"); // [R7]

   property p_spi;
      @(posedge MCLK) disable iff (RESET)
      SPI_UNIT_ENABLE |-> PIN_OE[27:24] == 4'h0;
   endproperty
   a_spi: assert property (p_spi) else $error("spi pins still driven"); // [R8]

   property p_led;
      @(posedge MCLK) disable iff (RESET)
      LED_SINK[0] |-> s_q.dir_q[1][0] && s_q.led_q[0];
   endproperty
   a_led: assert property (p_led) else $error("led sink on input pin"); // [R12]

   property p_read_zero;
      @(posedge MCLK) disable iff (RESET)
      (AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 4'hc && CLK_EN)
      |=> AVS_READDATA[31:6] == 26'h0;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("reserved bits nonzero"); // [R13]

   // a request is taken at the edge that still sees waitrequest high;
   // its effect shows one edge later, which is where these checks look
   sequence s_write_taken;
      AVS_WRITE && AVS_WAITREQUEST && AVS_BYTEENABLE[0] && CLK_EN;
   endsequence

   sequence s_read_taken;
      AVS_READ && AVS_WAITREQUEST && CLK_EN;
   endsequence

   property p_dir_write;
      @(posedge MCLK) disable iff (RESET)
      s_write_taken ##0 (AVS_ADDRESS == 4'h4) |=> s_q.dir_q[0] == $past(AVS_WRITEDATA[7:0]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost"); // [R3]

   property p_write_one_cycle;
      @(posedge MCLK) disable iff (RESET)
      s_write_taken |=> !AVS_WAITREQUEST;
   endproperty
   a_write_one_cycle: assert property (p_write_one_cycle) else $error("write not one cycle"); // [R13]

   property p_led_write;
      @(posedge MCLK) disable iff (RESET)
      s_write_taken ##0 (AVS_ADDRESS == 4'hc)
      |=> s_q.led_q == ($past(AVS_WRITEDATA[7:0]) & `LED_MASK);
   endproperty
   a_led_write: assert property (p_led_write) else $error("led enable write wrong"); // [R13]

   property p_unmapped_write;
      @(posedge MCLK) disable iff (RESET)
      s_write_taken ##0 (AVS_ADDRESS inside {[4'h8:4'hb], [4'hd:4'hf]})
      |=> $stable(s_q.dir_q) && $stable(s_q.led_q);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("gap write landed"); // [R13]

   property p_read_dir;
      @(posedge MCLK) disable iff (RESET)
      s_read_taken ##0 (AVS_ADDRESS == 4'h5) |=> AVS_READDATA == {24'h0, $past(s_q.dir_q[1])};
   endproperty
   a_read_dir: assert property (p_read_dir) else $error("direction read wrong"); // [R2]

   property p_read_output;
      @(posedge MCLK) disable iff (RESET)
      s_read_taken ##0 (AVS_ADDRESS == 4'h0 && s_q.dir_q[0] == 8'hff)
      |=> AVS_READDATA == {24'h0, $past(s_q.latch_q[0])};
   endproperty
   a_read_output: assert property (p_read_output) else $error("output pin read wrong"); // [R10]

   property p_read_input;
      @(posedge MCLK) disable iff (RESET)
      s_read_taken ##0 (AVS_ADDRESS == 4'h2 && s_q.dir_q[2] == 8'h00)
      |=> AVS_READDATA == {24'h0, $past(s_q.pin_q[2])};
   endproperty
   a_read_input: assert property (p_read_input) else $error("input pin read wrong"); // [R10]

   property p_rdata_hold;
      @(posedge MCLK) disable iff (RESET)
      !(AVS_READ && AVS_WAITREQUEST && CLK_EN) |=> $stable(AVS_READDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [R13]

   property p_ack_returns;
      @(posedge MCLK) disable iff (RESET)
      (s_q.bus_q == BUS_ACK) && CLK_EN |=> s_q.bus_q == BUS_IDLE;
   endproperty
   a_ack_returns: assert property (p_ack_returns) else $error("bus stuck in answer"); // [R13]

   property p_pin_hold;
      @(posedge MCLK) disable iff (RESET)
      CLK_EN && (s_q.sync2_q[0][0] != s_q.sync3_q[0][0])
      |=> s_q.pin_q[0][0] == $past(s_q.pin_q[0][0]);
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("pin taken before agreement"); // [R10]

   property p_pin_agree;
      @(posedge MCLK) disable iff (RESET)
      CLK_EN && (s_q.sync2_q[0][0] == s_q.sync3_q[0][0])
      |=> s_q.pin_q[0][0] == $past(s_q.sync3_q[0][0]);
   endproperty
   a_pin_agree: assert property (p_pin_agree) else $error("agreed pin not taken"); // [R10]

   property p_freeze;
      @(posedge MCLK) disable iff (RESET)
      !CLK_EN |=> $stable(s_q.dir_q) && $stable(s_q.pin_q) && $stable(s_q.bus_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // [R13]

   property p_owned_release;
      @(posedge MCLK) disable iff (RESET)
      (PIN_OE & PIN_PERIPH) == 32'h0000_0000;
   endproperty
   a_owned_release: assert property (p_owned_release) else $error("owned pin driven"); // [R6]

   property p_out_only_driven;
      @(posedge MCLK) disable iff (RESET)
      (PIN_OUT & ~PIN_OE) == 32'h0000_0000;
   endproperty
   a_out_only_driven: assert property (p_out_only_driven) else $error("output on input pin"); // [R3]

   property p_serial;
      @(posedge MCLK) disable iff (RESET)
      SERIAL_INTERFACE_ENABLE |-> PIN_PERIPH[9:8] == 2'b11 && PIN_OE[9:8] == 2'b00;
   endproperty
   a_serial: assert property (p_serial) else $error("serial pins not handed over"); // [R8]

   property p_frontplane;
      @(posedge MCLK) disable iff (RESET)
      FRONTPLANE_LOW_HALF_ENABLE |-> PIN_PERIPH[19:16] == 4'hf && PIN_OE[19:16] == 4'h0;
   endproperty
   a_frontplane: assert property (p_frontplane) else $error("frontplane pins driven"); // [R8]

   property p_keypad_hi;
      @(posedge MCLK) disable iff (RESET)
      KEYPAD_CHANNEL_ENABLE[7] |-> PIN_PERIPH[31] && !PIN_OE[31];
   endproperty
   a_keypad_hi: assert property (p_keypad_hi) else $error("keypad high pin driven"); // [R6]

   property p_analog_none;
      @(posedge MCLK) disable iff (RESET)
      (ANALOG_CHANNEL_SELECT >= 5'h06) |-> PIN_PERIPH[15:14] == 2'b00 && PIN_PERIPH[7:4] == 4'h0;
   endproperty
   a_analog_none: assert property (p_analog_none) else $error("analog pin taken"); // [R7]

   property p_led_output;
      @(posedge MCLK) disable iff (RESET)
      (LED_SINK & ~s_q.dir_q[1][5:0]) == 6'h00;
   endproperty
   a_led_output: assert property (p_led_output) else $error("led sink on input"); // [R12]

endmodule : parallel_io_ports

// File: dv/pin_board.sv
// Purpose: board side of the 32 port pins
// Assumes: an undriven pin sits at the level the board puts on it
// Notes:   a driven pin reads back what the block drives
`timescale 1ns/1ps
module pin_board (
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   input  wire logic [31:0] board_level,
   output logic      [31:0] pin_level
);
   // the block owns a pin only while its enable is high
   assign pin_level = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule : pin_board

// File: dv/testbench.sv
// Purpose: random and corner tests of the four-port parallel I/O block
// Assumes: one clock, Avalon-MM with waitrequest, low byte lane
// Notes:   expected values come from bench constants, inline expressions and the owned function
`timescale 1ns/1ps
module testbench;
   import gpio_pkg::*;
   logic        MCLK = 0, RESET = 1, AVS_READ = 0, AVS_WRITE = 0, clk_en = 1;
   logic [3:0]  AVS_ADDRESS = 0, tel = 0;
   logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, PIN_IN, PIN_OUT, PIN_OE, PIN_PERIPH;
   logic [31:0] ext = 0;
   logic        AVS_WAITREQUEST, sie = 0, fle = 0, fhe = 0, spi_unit_enable = 0;
   logic [5:0]  LED_SINK;
   logic [7:0]  kbe = 0;
   logic [4:0]  acs = 5'h1f;
   int          error_cnt = 0, n_checks = 0, seed = 32'h6d22, p;
   byte_t       q, lat, dir;

   always #25 MCLK = ~MCLK;

   parallel_io_ports u_dut (.MCLK(MCLK), .RESET(RESET), .CLK_EN(clk_en),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
      .PIN_OE(PIN_OE), .PIN_PERIPH(PIN_PERIPH), .LED_SINK(LED_SINK),
      .KEYPAD_CHANNEL_ENABLE(kbe), .ANALOG_CHANNEL_SELECT(acs),
      .SERIAL_INTERFACE_ENABLE(sie), .TIMER_EDGE_LEVEL_SELECT(tel),
      .FRONTPLANE_LOW_HALF_ENABLE(fle), .FRONTPLANE_HIGH_HALF_ENABLE(fhe),
      .SPI_UNIT_ENABLE(spi_unit_enable));

   pin_board u_board (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .board_level(ext),
      .pin_level(PIN_IN));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // entered just after a rising edge; holds the request until waitrequest is
   // sampled low at a rising edge, takes read data there, releases, lets one edge pass
   task automatic bus(input logic wr, input logic [3:0] a, input byte_t d, output byte_t r);
      int n;
      n = 0;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= {24'h0, d};
      AVS_READ <= !wr;
      AVS_WRITE <= wr;
      do begin
         @(posedge MCLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0);
      check(n, 32'h2);
      r = AVS_READDATA[7:0];
      AVS_READ <= 0;
      AVS_WRITE <= 0;
      @(posedge MCLK);
   endtask : bus

   function automatic logic [31:0] owned(input logic [7:0] k, input logic [4:0] a,
      input logic s, input logic [3:0] t, input logic l, input logic h, input logic sp);
      owned = {k[7:4], {4{sp}}, {4{h}}, {4{l}}, 2'b00, t, {2{s}}, 4'h0, k[3:0]};
      if (a < 4) owned[4 + a] = 1'b1;
      else if (a < 6) owned[10 + a] = 1'b1;
   endfunction : owned

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   initial begin
      #(50 * 40000);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (12) @(posedge MCLK);
      RESET <= 0;
      @(posedge MCLK);
      // directions, the unmapped gap and the led register all read zero
      for (int i = 4; i < 13; i++) begin
         bus(0, i[3:0], 8'h00, q);
         check({24'h0, q}, 32'h0);
      end
      check(PIN_OE, 32'h0);
      bus(1, 4'h0, 8'h5a, q);
      RESET <= 1;
      @(posedge MCLK);
      RESET <= 0;
      @(posedge MCLK);
      bus(1, 4'h4, 8'hff, q);
      bus(0, 4'h0, 8'h00, q);
      check({24'h0, q}, 32'h5a);
      bus(1, 4'h9, 8'hff, q);
      bus(0, 4'h9, 8'h00, q);
      check({24'h0, q}, 32'h0);
      $display("reset and map test done");
      // port C is input here; a frozen sampler must still show the old level
      clk_en <= 0;
      ext <= 32'h00a5_0000;
      repeat (8) @(posedge MCLK);
      clk_en <= 1;
      bus(0, 4'h2, 8'h00, q);
      check({24'h0, q}, 32'h0);
      repeat (8) @(posedge MCLK);
      bus(0, 4'h2, 8'h00, q);
      check({24'h0, q}, 32'ha5);
      $display("clock enable test done");
      for (int i = 0; i < 32; i++) begin
         p = $unsigned($random(seed)) % 4;
         lat = $random(seed);
         dir = $random(seed);
         ext <= $random(seed);
         bus(1, p[3:0], lat, q); // latch loaded before the driver turns on
         bus(1, 4'h4 + p[3:0], dir, q);
         repeat (8) @(posedge MCLK);
         bus(0, p[3:0], 8'h00, q);
         check({24'h0, q}, {24'h0, (lat & dir) | (ext[8*p +: 8] & ~dir)});
         bus(0, 4'h4 + p[3:0], 8'h00, q);
         check({24'h0, q}, {24'h0, dir});
         check({24'h0, PIN_OE[8*p +: 8]}, {24'h0, dir});
         check({24'h0, PIN_OUT[8*p +: 8]}, {24'h0, lat & dir});
      end
      $display("random port test done");
      bus(1, 4'h5, 8'h2d, q);
      bus(1, 4'hc, 8'hff, q);
      bus(0, 4'hc, 8'h00, q);
      check({24'h0, q}, 32'h3f);
      check({26'h0, LED_SINK}, 32'h2d);
      $display("led test done");
      for (int i = 4; i < 8; i++) bus(1, i[3:0], 8'hff, q);
      for (int i = 0; i < 8; i++) begin
         acs <= i[4:0];
         kbe <= $random(seed);
         tel <= $random(seed);
         {sie, fle, fhe, spi_unit_enable} <= $random(seed);
         @(negedge MCLK);
         check(PIN_PERIPH, owned(kbe, acs, sie, tel, fle, fhe, spi_unit_enable));
         check(PIN_OE, ~owned(kbe, acs, sie, tel, fle, fhe, spi_unit_enable));
         @(posedge MCLK);
      end
      $display("pin sharing test done");
      report_and_stop();
   end
endmodule : testbench
